/* File: hw/gats_map.vh */
// Constants and register map of the aiding and time sync block
// Notes on behaviour
// R1: Aiding port frames are one start, eight data, one stop bit, no parity.
// R2: Aiding bit rates 9600, 19200, 38400, 57600 selectable; 57600 preferred.
// R3: Receiver must send position, velocity and status messages at 4 Hz.
// R4: Received aiding bytes are used only when aiding is enabled in configuration.
// R5: Aiding-absent flag clear only while valid 3D-fix messages arrive, else set.
// R6: Marine sentence aiding lacks vertical velocity; derived from altitude steps.
// R7: With a second pulse, sampling locks to it; exactly 100 ticks per second.
// R8: Data valid at pulse edge and each 10 ms after; sampling lags up to 500 us.
// R9: Pulse-unlocked flag clear while locked to the second pulse, else set.
// R10: Second pulse output aligned to the sampling clock, 43 ns granularity; here 40 ns, from the 25 MHz clock.
// R11: Second pulse output only when time is known; edge on the second boundary.
// R12: Consumers detect the second pulse on its rising edge.
// R13: Without internal receiver, sampling locks to an external 1 kHz sync pulse.
// R14: Host waits at least 60 s after power-up before trusting output data.
// R15: Default receiver messages use the same 8N1 framing, no flow control.
// R16: Without lock, the 10 ms cadence free-runs from the local clock.
`ifndef GATS_MAP_VH
`define GATS_MAP_VH
`define GATS_CLK_HZ 25000000
`define GATS_ADDR_CTRL 4'h0
`define GATS_ADDR_STATUS 4'h1
`define GATS_ADDR_DATA 4'h2
`define GATS_ADDR_VVEL 4'h3
`define GATS_CTRL_AID_EN 0
`define GATS_CTRL_RATE_LO 1
`define GATS_CTRL_RATE_HI 2
`define GATS_CTRL_MARINE 3
`define GATS_CTRL_TIME_KNOWN 4
`define GATS_CTRL_FIX3D 5
`define GATS_CTRL_EXT_SYNC 6
`define GATS_CTRL_RESET 8'h00
`define GATS_ST_AID_ABSENT 0
`define GATS_ST_UNLOCKED 1
`define GATS_ST_DATA_VALID 2
`define GATS_ST_RX_ERR 3
`define GATS_BAUD_9600 16'd2604
`define GATS_BAUD_19200 16'd1302
`define GATS_BAUD_38400 16'd651
`define GATS_BAUD_57600 16'd434
`define GATS_TICK_NS 10000000
`define GATS_TICK_CYC (`GATS_CLK_HZ / 100)
`define GATS_MS_CYC (`GATS_CLK_HZ / 1000)
`define GATS_TICKS_PER_SEC 7'd100
`define GATS_MS_PER_TICK 4'd10
`define GATS_AID_TIMEOUT_CYC (`GATS_CLK_HZ / 2)
`endif

/* File: hw/gats_fifo2.v */
// Two-entry buffer for received aiding bytes
`timescale 1ns/1ns
`default_nettype none
module gats_fifo2 #(
   parameter WIDTH = 8
) (
   input wire clk, // Clock
   input wire rst_n, // Async reset, active low
   input wire in_valid, // Write side valid
   output wire in_ready, // Write side ready
   input wire [WIDTH-1:0] in_data, // Write data
   output wire out_valid, // Read side valid
   input wire out_ready, // Read side ready
   output wire [WIDTH-1:0] out_data // Read data, from a register
);
   reg [WIDTH-1:0] mem_reg [0:1];
   reg wr_ptr_reg;
   reg rd_ptr_reg;
   reg [1:0] count_reg;
   wire do_wr;
   wire do_rd;
   // Handshakes
   assign in_ready = (count_reg != 2'd2);
   assign out_valid = (count_reg != 2'd0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign do_wr = in_valid & in_ready;
   assign do_rd = out_valid & out_ready;
   // Pointers and occupancy
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'd0;
         mem_reg[0] <= {WIDTH{1'b0}};
         mem_reg[1] <= {WIDTH{1'b0}};
      end
      else
      begin
         if (do_wr)
         begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (do_rd)
            rd_ptr_reg <= ~rd_ptr_reg;
         if (do_wr & ~do_rd)
            count_reg <= count_reg + 2'd1;
         else if (do_rd & ~do_wr)
            count_reg <= count_reg - 2'd1;
      end
   end
endmodule // gats_fifo2
`default_nettype wire

/* File: hw/gats_top.v */
// Aiding receiver, pulse lock and navigation tick generator
`timescale 1ns/1ns
`default_nettype none
`include "gats_map.vh"
module gats_top (
   input wire CLOCK, // 25 MHz clock
   input wire RESETN, // Async reset, active low
   input wire [3:0] ADDR, // Register address
   input wire [7:0] WDATA, // Register write data
   input wire WR, // Write strobe
   input wire RD, // Read strobe
   output reg [7:0] RDATA, // Read data, one cycle after RD
   input wire AID_RXD, // Aiding serial input
   input wire PULSE_IN, // Pulse input, second or 1 kHz
   output wire PULSE_OUT, // Second pulse output drive level
   output wire PULSE_OE, // Second pulse output enable
   output reg NAV_TICK, // One-cycle 10 ms navigation tick
   output wire EXT_AID_ABSENT, // Aiding-absent flag
   output wire PULSE_UNLOCKED // Pulse-unlocked flag
);
   // Control, synchronisers and serial receiver state
   reg [7:0] ctrl_reg;
   reg [1:0] rxd_sync_reg;
   reg [1:0] pin_sync_reg;
   reg pin_last_reg;
   reg [15:0] baud_cnt_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] shift_reg;
   reg rx_busy_reg;
   reg rx_err_reg;
   reg byte_valid_reg;
   reg [7:0] byte_reg;
   // Aiding age, navigation cadence and pulse lock state
   reg [24:0] aid_age_reg;
   reg [24:0] tick_cnt_reg;
   reg [6:0] tick_num_reg;
   reg [3:0] ms_num_reg;
   reg locked_reg;
   reg [25:0] lock_age_reg;
   reg pulse_out_reg;
   // Altitude history for the vertical speed estimate
   reg [7:0] alt_lo_reg;
   reg [15:0] alt_cur_reg;
   reg alt_hi_reg;
   reg [15:0] vvel_reg;
   reg [15:0] baud_div;
   // Long counts cut to the width of the counters that hold them
   localparam [31:0] AID_TIMEOUT_FULL = `GATS_AID_TIMEOUT_CYC;
   localparam [24:0] AID_TIMEOUT = AID_TIMEOUT_FULL[24:0];
   localparam [31:0] TICK_LAST_FULL = `GATS_TICK_CYC - 1;
   localparam [24:0] TICK_LAST = TICK_LAST_FULL[24:0];
   // Lock lost after one second plus two ticks without an edge
   localparam [31:0] SEC_WINDOW_FULL = `GATS_CLK_HZ + `GATS_CLK_HZ / 50;
   localparam [25:0] SEC_WINDOW = SEC_WINDOW_FULL[25:0];
   // In 1 kHz mode lock is lost after two missed edges
   localparam [31:0] MS_WINDOW_FULL = `GATS_MS_CYC * 2;
   localparam [25:0] MS_WINDOW = MS_WINDOW_FULL[25:0];
   // Synchronised line, control decode and buffer handshake
   wire rxd_s;
   wire pin_rise;
   wire aid_en;
   wire ext_sync;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire fifo_pop;
   wire aid_absent;
   wire [25:0] lock_window;
   assign rxd_s = rxd_sync_reg[1];
   assign aid_en = ctrl_reg[`GATS_CTRL_AID_EN];
   assign ext_sync = ctrl_reg[`GATS_CTRL_EXT_SYNC];
   // Synchronise the pins, edge detect on the second stage only
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rxd_sync_reg <= 2'b11;
         pin_sync_reg <= 2'b00;
         pin_last_reg <= 1'b0;
      end
      else
      begin
         rxd_sync_reg <= {rxd_sync_reg[0], AID_RXD};
         pin_sync_reg <= {pin_sync_reg[0], PULSE_IN};
         pin_last_reg <= pin_sync_reg[1];
      end
   end
   assign pin_rise = pin_sync_reg[1] & ~pin_last_reg; // R12
   // Bit period for the selected rate
   always @*
   begin
      case (ctrl_reg[`GATS_CTRL_RATE_HI:`GATS_CTRL_RATE_LO]) // R2
         2'd0: baud_div = `GATS_BAUD_9600;
         2'd1: baud_div = `GATS_BAUD_19200;
         2'd2: baud_div = `GATS_BAUD_38400;
         default: baud_div = `GATS_BAUD_57600;
      endcase
   end
   // 8N1 receiver, sampled mid bit
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rx_busy_reg <= 1'b0;
         baud_cnt_reg <= 16'h0000;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_valid_reg <= 1'b0;
         byte_reg <= 8'h00;
         rx_err_reg <= 1'b0;
      end
      else
      begin
         // A free buffer slot takes the pending byte this cycle
         if (fifo_in_ready)
            byte_valid_reg <= 1'b0;
         // Software clears the sticky error; an error in the same cycle wins
         if (WR && ADDR == `GATS_ADDR_STATUS && WDATA[`GATS_ST_RX_ERR])
            rx_err_reg <= 1'b0;
         // Idle: a low line starts a frame, the first wait is half a bit
         if (!rx_busy_reg)
         begin
            if (!rxd_s && aid_en) // R4
            begin
               rx_busy_reg <= 1'b1;
               baud_cnt_reg <= {1'b0, baud_div[15:1]};
               bit_cnt_reg <= 4'h0;
            end
         end
         else if (baud_cnt_reg != 16'h0000)
            baud_cnt_reg <= baud_cnt_reg - 16'h0001;
         else
         begin
            baud_cnt_reg <= baud_div - 16'h0001;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            // Mid start bit still high: a glitch, the frame is dropped
            if (bit_cnt_reg == 4'h0 && rxd_s) // R1
               rx_busy_reg <= 1'b0;
            else if (bit_cnt_reg >= 4'h1 && bit_cnt_reg <= 4'h8)
               shift_reg <= {rxd_s, shift_reg[7:1]}; // R1
            else if (bit_cnt_reg == 4'h9)
            begin
               // Stop bit: the byte moves to its own holding register, so the
               // next frame shifting in cannot spoil a byte that waits for room
               rx_busy_reg <= 1'b0;
               if (rxd_s && !(byte_valid_reg && !fifo_in_ready)) // R15
               begin
                  byte_valid_reg <= 1'b1;
                  byte_reg <= shift_reg;
               end
               else
                  rx_err_reg <= 1'b1; // Framing error or overrun, set wins
            end
         end
      end
   end
   // Two-entry buffer between the receiver and the data register
   gats_fifo2 #(
      .WIDTH(8)
   ) u_fifo (
      .clk(CLOCK),
      .rst_n(RESETN),
      .in_valid(byte_valid_reg),
      .in_ready(fifo_in_ready),
      .in_data(byte_reg),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );
   // A data read pops the buffer; a read of an empty buffer pops nothing
   assign fifo_pop = RD && ADDR == `GATS_ADDR_DATA;
   // Aiding freshness: valid bytes with a 3D fix keep the flag clear
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
         aid_age_reg <= AID_TIMEOUT;
      else if (byte_valid_reg && fifo_in_ready && aid_en)
         aid_age_reg <= 25'd0;
      else if (aid_age_reg != AID_TIMEOUT)
         aid_age_reg <= aid_age_reg + 25'd1;
   end
   // Fix bit is set by software once it has parsed a 3D fix; the timeout
   // spans two message periods, so one lost message does not raise the flag
   assign aid_absent = !(aid_en && ctrl_reg[`GATS_CTRL_FIX3D]
      && aid_age_reg != AID_TIMEOUT); // R5
   assign EXT_AID_ABSENT = aid_absent; // R5
   // Altitude pairs from software, vertical velocity per update
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         alt_lo_reg <= 8'h00;
         alt_cur_reg <= 16'h0000;
         alt_hi_reg <= 1'b0;
         vvel_reg <= 16'h0000;
      end
      else if (WR && ADDR == `GATS_ADDR_VVEL && ctrl_reg[`GATS_CTRL_MARINE])
      begin
         // Low byte waits apart, so the old altitude stays whole until the pair ends
         alt_hi_reg <= ~alt_hi_reg;
         if (!alt_hi_reg)
            alt_lo_reg <= WDATA;
         else
         begin
            alt_cur_reg <= {WDATA, alt_lo_reg};
            vvel_reg <= {WDATA, alt_lo_reg} - alt_cur_reg; // R6
         end
      end
   end
   // 10 ms tick cadence, restarted by the pulse when locked
   assign lock_window = ext_sync ? MS_WINDOW : SEC_WINDOW;
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         tick_cnt_reg <= 25'd0;
         tick_num_reg <= 7'd0;
         ms_num_reg <= 4'd0;
         NAV_TICK <= 1'b0;
         locked_reg <= 1'b0;
         lock_age_reg <= 26'd0;
         pulse_out_reg <= 1'b0;
      end
      else
      begin
         NAV_TICK <= 1'b0;
         // Lock age restarts at every edge; lock drops when it saturates
         if (pin_rise)
            lock_age_reg <= 26'd0;
         else if (lock_age_reg != lock_window)
            lock_age_reg <= lock_age_reg + 26'd1;
         if (lock_age_reg == lock_window)
            locked_reg <= 1'b0; // R9
         // Second mode: the edge restarts the cadence at tick zero
         if (pin_rise && !ext_sync)
         begin
            locked_reg <= 1'b1; // R7
            tick_cnt_reg <= 25'd0;
            tick_num_reg <= 7'd0;
            NAV_TICK <= 1'b1; // R8
         end
         // 1 kHz mode: every tenth edge is a tick
         else if (pin_rise && ext_sync)
         begin
            locked_reg <= 1'b1; // R13
            if (ms_num_reg == `GATS_MS_PER_TICK - 4'd1)
            begin
               ms_num_reg <= 4'd0;
               tick_cnt_reg <= 25'd0;
               NAV_TICK <= 1'b1; // R13
            end
            else
               ms_num_reg <= ms_num_reg + 4'd1;
         end
         // Free run; the first tick of a locked second waits for the edge
         else if (tick_cnt_reg == TICK_LAST)
         begin
            tick_cnt_reg <= 25'd0; // R16
            if (!(locked_reg && !ext_sync && tick_num_reg == `GATS_TICKS_PER_SEC - 7'd1))
            begin
               NAV_TICK <= 1'b1; // R16
               tick_num_reg <= (tick_num_reg == `GATS_TICKS_PER_SEC - 7'd1) ?
                  7'd0 : tick_num_reg + 7'd1;
            end
         end
         else
            tick_cnt_reg <= tick_cnt_reg + 25'd1;
         // Output pulse is high for the first ten ticks of each second
         pulse_out_reg <= ctrl_reg[`GATS_CTRL_TIME_KNOWN] && tick_num_reg < 7'd10; // R11
      end
   end
   // Open-collector second pulse: pull low when output is low
   // The pin is pulled up outside, so the edge rises as tick zero starts
   assign PULSE_OUT = 1'b0;
   assign PULSE_OE = ctrl_reg[`GATS_CTRL_TIME_KNOWN] & ~pulse_out_reg; // R10
   assign PULSE_UNLOCKED = ~locked_reg; // R9
   // Register writes
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
         ctrl_reg <= `GATS_CTRL_RESET;
      else if (WR && ADDR == `GATS_ADDR_CTRL)
         ctrl_reg <= WDATA;
   end
   // Register reads, data one cycle after the strobe
   // Unmapped addresses and idle cycles read as zero
   always @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
         RDATA <= 8'h00;
      else if (RD)
      begin
         case (ADDR)
            `GATS_ADDR_CTRL: RDATA <= ctrl_reg;
            `GATS_ADDR_STATUS: RDATA <= {4'h0, rx_err_reg, fifo_out_valid,
               ~locked_reg, aid_absent};
            `GATS_ADDR_DATA: RDATA <= fifo_out_data;
            `GATS_ADDR_VVEL: RDATA <= vvel_reg[7:0];
            default: RDATA <= 8'h00;
         endcase
      end
      else
         RDATA <= 8'h00;
   end
endmodule // gats_top
`default_nettype wire

/* File: sim/gats_top_asserts.sv */
// Property checker for the aiding and pulse lock block
`timescale 1ns/1ns
`default_nettype none
module gats_top_asserts (
   input wire logic CLOCK, // Clock
   input wire logic RESETN, // Reset
   input wire logic [3:0] ADDR, // Address
   input wire logic [7:0] WDATA, // Write data
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   input wire logic [7:0] RDATA, // Read data
   input wire logic PULSE_IN, // Pulse in
   input wire logic PULSE_OE, // Pulse drive
   input wire logic NAV_TICK, // Tick
   input wire logic EXT_AID_ABSENT, // Aiding absent
   input wire logic PULSE_UNLOCKED // Not locked
);
   logic [7:0] ctrl_reg;
   logic [17:0] gap_reg;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   // Control copy and cycles since the last tick
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ctrl_reg <= 8'h00;
         gap_reg <= 18'h00000;
      end
      else
      begin
         if (WR && ADDR == 4'h0)
            ctrl_reg <= WDATA;
         gap_reg <= NAV_TICK ? 18'h00000 : gap_reg + 18'h00001;
      end
   end
   property p_aid_en;
      !ctrl_reg[0] && !$past(ctrl_reg[0]) |-> EXT_AID_ABSENT;
   endproperty
   a_aid_en: assert property (p_aid_en) else $error("aiding used while off");
   property p_fix;
      !ctrl_reg[5] && !$past(ctrl_reg[5]) |-> EXT_AID_ABSENT;
   endproperty
   a_fix: assert property (p_fix) else $error("aiding present without fix");
   property p_stat;
      RD && ADDR == 4'h1 |=> RDATA[0] == $past(EXT_AID_ABSENT)
         && RDATA[1] == $past(PULSE_UNLOCKED);
   endproperty
   a_stat: assert property (p_stat) else $error("status read differs from flags");
   property p_oe;
      !ctrl_reg[4] && !$past(ctrl_reg[4]) |-> !PULSE_OE;
   endproperty
   a_oe: assert property (p_oe) else $error("second pulse driven without time");
   property p_tick;
      $rose(PULSE_IN) && !ctrl_reg[6] |-> ##[2:4] NAV_TICK;
   endproperty
   a_tick: assert property (p_tick) else $error("no tick after second pulse");
   property p_lock;
      $rose(PULSE_IN) && !ctrl_reg[6] |-> ##[2:4] !PULSE_UNLOCKED;
   endproperty
   a_lock: assert property (p_lock) else $error("no lock after second pulse");
   property p_one;
      NAV_TICK |=> !NAV_TICK;
   endproperty
   a_one: assert property (p_one) else $error("tick longer than one cycle");
   property p_gap;
      gap_reg <= 18'h3D090;
   endproperty
   a_gap: assert property (p_gap) else $error("tick cadence lost");
   c_tick: cover property (NAV_TICK && !PULSE_UNLOCKED);
   c_aid: cover property (!EXT_AID_ABSENT);
   c_vvel: cover property (RD && ADDR == 4'h3);
endmodule // gats_top_asserts
bind gats_top gats_top_asserts gats_top_asserts_inst (.CLOCK(CLOCK), .RESETN(RESETN),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PULSE_IN(PULSE_IN),
   .PULSE_OE(PULSE_OE), .NAV_TICK(NAV_TICK), .EXT_AID_ABSENT(EXT_AID_ABSENT),
   .PULSE_UNLOCKED(PULSE_UNLOCKED));
`default_nettype wire

/* File: sim/gats_rcv_model.sv */
// Satellite receiver and sync pulse source model
`timescale 1ns/1ns
`default_nettype none
module gats_rcv_model (
   input wire logic clk, // Clock
   output logic txd, // Serial line, idle high
   output logic pulse // Pulse, low between pulses
);
   // Lines rest at idle level
   initial
   begin
      txd = 1'b1;
      pulse = 1'b0;
   end
   // One frame, LSB first, bc clocks per bit
   task automatic send(input logic [7:0] b, input int bc);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk);
         txd <= f[i];
         repeat (bc - 1) @(posedge clk);
      end
   endtask
   // One pulse, rising edge marks the event
   task automatic pulse_once(input int hi, input int lo);
      @(posedge clk);
      pulse <= 1'b1;
      repeat (hi) @(posedge clk);
      pulse <= 1'b0;
      repeat (lo) @(posedge clk);
   endtask
endmodule // gats_rcv_model
`default_nettype wire

/* File: sim/gats_top_tb.sv */
// Self-checking bench for the aiding and time sync block
`timescale 1ns/1ns
`default_nettype none
module gats_top_tb;
   logic CLOCK, RESETN, WR, RD;
   logic [3:0] ADDR, ua;
   logic [7:0] WDATA, rd_val, b0, b1, b2, b3;
   logic [31:0] alt;
   wire logic AID_RXD, PULSE_IN, PULSE_OUT, PULSE_OE, NAV_TICK, EXT_AID_ABSENT, PULSE_UNLOCKED;
   wire logic [7:0] RDATA;
   int mismatches = 0, checked = 0, cycles = 0, ticks = 0;
   int bit_cyc [4] = '{2604, 1302, 651, 434};
   gats_top gats_top_inst (.CLOCK(CLOCK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .AID_RXD(AID_RXD), .PULSE_IN(PULSE_IN),
      .PULSE_OUT(PULSE_OUT), .PULSE_OE(PULSE_OE), .NAV_TICK(NAV_TICK),
      .EXT_AID_ABSENT(EXT_AID_ABSENT), .PULSE_UNLOCKED(PULSE_UNLOCKED));
   gats_rcv_model gats_rcv_model_inst (.clk(CLOCK), .txd(AID_RXD), .pulse(PULSE_IN));
   // Clock
   initial
   begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   // Verdict and end of run
   task automatic finish_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Cycle limit and tick count
   always @(posedge CLOCK)
   begin
      cycles++;
      if (NAV_TICK === 1'b1)
         ticks++;
      if (cycles == 99000)
      begin
         mismatches++;
         finish_test;
      end
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", n, e, g);
         mismatches++;
      end
   endtask
   // Read, data taken in the cycle after the strobe, then compared
   task automatic rc(input logic [3:0] a, input string n, input logic [7:0] e);
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 rd_val = RDATA;
      chk(n, e, rd_val);
   endtask
   // Vertical speed from two altitude samples
   function automatic logic [7:0] vv_exp(input logic [31:0] al);
      return al[23:16] - al[7:0];
   endfunction
   // Main sequence
   initial
   begin
      RESETN = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 4'h0;
      WDATA = 8'h00;
      void'($urandom(79140));
      repeat (12) @(posedge CLOCK);
      RESETN <= 1'b1;
      rc(4'h1, "status", 8'h03);
      ua = 4'($urandom_range(15, 4));
      wr(ua, 8'($urandom));
      rc(ua, "unmapped", 8'h00);
      rc(4'h0, "ctrl", 8'h00);
      b0 = 8'($urandom);
      wr(4'h0, 8'h06);
      gats_rcv_model_inst.send(b0, 434);
      rc(4'h1, "status", 8'h03);
      wr(4'h0, 8'h07);
      gats_rcv_model_inst.send(b0, 434);
      rc(4'h1, "status", 8'h07);
      rc(4'h2, "data", b0);
      for (int r = 0; r < 4; r++)
      begin
         wr(4'h0, 8'h21 | 8'(r << 1));
         b0 = 8'($urandom);
         gats_rcv_model_inst.send(b0, bit_cyc[r]);
         rc(4'h1, "status", 8'h06);
         chk("absent", 8'h00, {7'h00, EXT_AID_ABSENT});
         rc(4'h2, "data", b0);
      end
      // Overflow: two bytes fill the buffer, one waits, the fourth is lost
      b0 = 8'hFF;
      b1 = 8'h00;
      b2 = 8'($urandom);
      b3 = 8'($urandom);
      gats_rcv_model_inst.send(b0, 434);
      gats_rcv_model_inst.send(b1, 434);
      gats_rcv_model_inst.send(b2, 434);
      gats_rcv_model_inst.send(b3, 434);
      rc(4'h1, "status", 8'h0E);
      rc(4'h2, "data", b0);
      rc(4'h2, "data", b1);
      wr(4'h1, 8'h08);
      rc(4'h1, "status", 8'h06);
      rc(4'h2, "data", b2);
      rc(4'h1, "status", 8'h02);
      // Altitude pairs in marine mode
      wr(4'h0, 8'h08);
      alt = $urandom;
      for (int i = 0; i < 4; i++)
         wr(4'h3, alt[8 * i +: 8]);
      rc(4'h3, "vvel", vv_exp(alt));
      // Second pulse lock with time known
      wr(4'h0, 8'h10);
      ticks = 0;
      gats_rcv_model_inst.pulse_once(20, 10);
      chk("ticks", 8'h01, 8'(ticks));
      chk("oe", 8'h00, {7'h00, PULSE_OE});
      chk("out", 8'h00, {7'h00, PULSE_OUT});
      chk("unlocked", 8'h00, {7'h00, PULSE_UNLOCKED});
      rc(4'h1, "status", 8'h01);
      // External 1 kHz sync
      wr(4'h0, 8'h40);
      ticks = 0;
      repeat (20) gats_rcv_model_inst.pulse_once(20, 80);
      chk("ticks", 8'h02, 8'(ticks));
      rc(4'h1, "status", 8'h01);
      finish_test;
   end
endmodule // gats_top_tb
`default_nettype wire
